// ==== bbc_cfg.svh ====
// timing, scaling, field widths and register addresses for the buck-boost mode and ramp control block
`ifndef BBC_CFG_SVH
`define BBC_CFG_SVH
`define BBC_CLK_HZ          10000000
`define BBC_SS_TYP_NS       180000
`define BBC_SS_MAX_NS       250000
`define BBC_SS_CYC          ((`BBC_SS_TYP_NS / (1000000000 / `BBC_CLK_HZ)))
`define BBC_STEP_UV         25000
`define BBC_RATE0_UV_PER_MS 1000000
`define BBC_RATE1_UV_PER_MS 2500000
`define BBC_RATE2_UV_PER_MS 5000000
`define BBC_RATE3_UV_PER_MS 10000000
`define BBC_STEP_CYC(r)     ((`BBC_STEP_UV * (`BBC_CLK_HZ / 1000)) / (r))
`define BBC_OFS_LO_MV       13'h0708
`define BBC_OFS_HI_MV       13'h07e9
`define BBC_LSB_MV          13'h0019
`define BBC_REV_LIMIT_MA    12'h514
`define BBC_CODE_W          7
`define BBC_CNT_W           16
`define BBC_SS_W            12
`define BBC_CTRL_W          6
`define BBC_ADDR_VSET1      4'h0
`define BBC_ADDR_VSET2      4'h1
`define BBC_ADDR_CTRL       4'h2
`define BBC_ADDR_STATUS     4'h3
`endif

// ==== bbc_pkg.sv ====
// types shared by the buck-boost control block
package bbc_pkg;
    typedef enum logic [1:0] {BBC_BUCK = 2'b00, BBC_BB = 2'b01, BBC_BOOST = 2'b11} bbc_mode_e;
    typedef enum logic [1:0] {BBC_OFF = 2'b00, BBC_SOFT = 2'b01, BBC_RUN = 2'b11} bbc_state_e;
    typedef struct packed {
        logic q1On;
        logic q2On;
        logic q3On;
        logic q4On;
    } bbc_gate_s;
    typedef struct packed {
        logic       enableBit;
        logic       forcedPulseWidthBit;
        logic       rampPulseWidthBit;
        logic       rangeBit;
        logic [1:0] slewCode;
    } bbc_ctrl_s;
endpackage

// ==== bbc_step_timer.sv ====
// ramp step interval timer selected by the slew code
`timescale 1ns/1ns
`include "bbc_cfg.svh"
module bbc_step_timer
    import bbc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic [1:0] slewCode,
    output logic            stepTick
);
    localparam logic [`BBC_CNT_W-1:0] RATE0 = `BBC_CNT_W'(`BBC_STEP_CYC(`BBC_RATE0_UV_PER_MS));
    localparam logic [`BBC_CNT_W-1:0] RATE1 = `BBC_CNT_W'(`BBC_STEP_CYC(`BBC_RATE1_UV_PER_MS));
    localparam logic [`BBC_CNT_W-1:0] RATE2 = `BBC_CNT_W'(`BBC_STEP_CYC(`BBC_RATE2_UV_PER_MS));
    localparam logic [`BBC_CNT_W-1:0] RATE3 = `BBC_CNT_W'(`BBC_STEP_CYC(`BBC_RATE3_UV_PER_MS));
    logic [`BBC_CNT_W-1:0] countReg;
    logic [`BBC_CNT_W-1:0] period;
    always_comb
    begin
        case (slewCode)
            2'h0:    period = RATE0;
            2'h1:    period = RATE1;
            2'h2:    period = RATE2;
            default: period = RATE3;
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst || !run)
            countReg <= '0;
        else if (countReg >= period - `BBC_CNT_W'(1))
            countReg <= '0;
        else
            countReg <= countReg + `BBC_CNT_W'(1);
    end
    assign stepTick = run && (countReg >= period - `BBC_CNT_W'(1));
endmodule // bbc_step_timer

// ==== bbc_control.sv ====
// mode selection, switch patterns, soft start and voltage ramp control
// Contract
// - mode chosen automatically from input versus output voltage, never by software.
// - buck: first switch controls, second rectifies, third off, fourth on.
// - boost: first on, second off, third controls, fourth rectifies.
// - on phase ends when sensed peak current reaches error amplifier reference.
// - forced pulse width keeps conduction with negative current, reverse limit 1.3 A.
// - power save is forced during startup until first power good.
// - forced pulse width bit resets to zero, power save by default.
// - power save bursts at light load when amplifier exceeds burst threshold.
// - forced pulse width keeps synchronous switches on with negative current.
// - enabled by enable pin high or enable bit; either may come first.
// - soft start ramps the reference about 180 us, never beyond 250 us.
// - setpoint spans 1.8 V to 5.2 V in 25 mV steps.
// - setpoint is code times 25 mV plus 1.8 V or 2.025 V offset.
// - select pin low picks first setting, high picks second.
// - ramp pulse width bit forces pulse width mode while ramping.
// - ramp moves the setpoint toward target in 25 mV steps.
// - two-bit slew code selects 1, 2.5, 5 or 10 V/ms.
// - select change or active write starts a ramp; before first good, immediate.
// - active-low power good low above 95 percent, high below 90 percent.
`timescale 1ns/1ns
`include "bbc_cfg.svh"
module bbc_control
    import bbc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic [3:0]             regAddr,
    input  wire logic [7:0]             regWrData,
    input  wire logic                   regWrStrobe,
    input  wire logic                   regRdStrobe,
    output logic      [7:0]             regRdData,
    input  wire logic                   enablePin,
    input  wire logic                   voltageSelectPin,
    input  wire logic                   vinAboveVout,
    input  wire logic                   voutAboveVin,
    input  wire logic                   peakReached,
    input  wire logic                   currentNegative,
    input  wire logic                   lightLoad,
    input  wire logic                   burstAboveThreshold,
    input  wire logic                   outAbove95,
    input  wire logic                   outBelow90,
    input  wire logic                   cycleStart,
    output bbc_gate_s                   gateDrive,
    output bbc_mode_e                   convMode,
    output logic                        forcedPwmActive,
    output logic      [12:0]            setpointMv,
    output logic      [`BBC_SS_W-1:0]   softStartLevel,
    output logic      [11:0]            reverseLimitMa,
    output logic                        powerGoodN
);
    localparam logic [3:0] ADDR_VSET1  = `BBC_ADDR_VSET1;
    localparam logic [3:0] ADDR_VSET2  = `BBC_ADDR_VSET2;
    localparam logic [3:0] ADDR_CTRL   = `BBC_ADDR_CTRL;
    localparam logic [3:0] ADDR_STATUS = `BBC_ADDR_STATUS;
    localparam logic [`BBC_SS_W-1:0] SS_CYC = `BBC_SS_W'(`BBC_SS_CYC);

    logic [1:0] enSync;
    logic [1:0] vselSync;
    logic [1:0] hiSync;
    logic [1:0] loSync;
    logic [1:0] a95Sync;
    logic [1:0] b90Sync;
    logic       enPinS;
    logic       vselS;
    logic       vinHiS;
    logic       voutHiS;
    logic       a95S;
    logic       b90S;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            enSync <= '0;
            vselSync <= '0;
            hiSync <= '0;
            loSync <= '0;
            a95Sync <= '0;
            b90Sync <= '0;
        end
        else
        begin
            enSync <= {enSync[0], enablePin};
            vselSync <= {vselSync[0], voltageSelectPin};
            hiSync <= {hiSync[0], vinAboveVout};
            loSync <= {loSync[0], voutAboveVin};
            a95Sync <= {a95Sync[0], outAbove95};
            b90Sync <= {b90Sync[0], outBelow90};
        end
    end
    assign enPinS  = enSync[1];
    assign vselS   = vselSync[1];
    assign vinHiS  = hiSync[1];
    assign voutHiS = loSync[1];
    assign a95S    = a95Sync[1];
    assign b90S    = b90Sync[1];

    logic [`BBC_CODE_W-1:0] vset1Reg;
    logic [`BBC_CODE_W-1:0] vset2Reg;
    bbc_ctrl_s              ctrlReg;
    logic                   wrActive;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            vset1Reg <= '0;
            vset2Reg <= '0;
            ctrlReg  <= '0;
        end
        else if (regWrStrobe)
        begin
            if (regAddr == ADDR_VSET1)
                vset1Reg <= regWrData[`BBC_CODE_W-1:0];
            else if (regAddr == ADDR_VSET2)
                vset2Reg <= regWrData[`BBC_CODE_W-1:0];
            else if (regAddr == ADDR_CTRL)
                ctrlReg <= regWrData[`BBC_CTRL_W-1:0];
        end
    end
    // a write counts only when it hits the register that is currently selected
    assign wrActive = regWrStrobe && ((regAddr == ADDR_VSET1 && !vselS) ||
                                      (regAddr == ADDR_VSET2 && vselS));

    bbc_state_e            stateReg;
    logic [`BBC_SS_W-1:0]  ssCountReg;
    logic                  firstGoodReg;
    logic                  pgNReg;
    logic                  enabled;
    assign enabled = enPinS || ctrlReg.enableBit;
    always_ff @(posedge clk)
    begin
        if (sys_rst || !enabled)
            stateReg <= BBC_OFF;
        else
        begin
            case (stateReg)
                BBC_OFF:  stateReg <= BBC_SOFT;
                BBC_SOFT: if (ssCountReg == SS_CYC) stateReg <= BBC_RUN;
                default:  stateReg <= BBC_RUN;
            endcase
        end
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst || stateReg == BBC_OFF)
            ssCountReg <= '0;
        else if (stateReg == BBC_SOFT && ssCountReg != SS_CYC)
            ssCountReg <= ssCountReg + `BBC_SS_W'(1);
    end
    assign softStartLevel = ssCountReg;
    always_ff @(posedge clk)
    begin
        if (sys_rst || stateReg == BBC_OFF)
            pgNReg <= 1'b1;
        else if (a95S)
            pgNReg <= 1'b0;
        else if (b90S)
            pgNReg <= 1'b1;
    end
    assign powerGoodN = pgNReg;
    always_ff @(posedge clk)
    begin
        if (sys_rst || stateReg == BBC_OFF)
            firstGoodReg <= 1'b0;
        else if (stateReg == BBC_RUN && !pgNReg)
            firstGoodReg <= 1'b1;
    end

    logic [`BBC_CODE_W-1:0] targetCode;
    logic [`BBC_CODE_W-1:0] curCodeReg;
    logic                   vselPrevReg;
    logic                   rangePrevReg;
    logic                   ramping;
    logic                   rampStart;
    logic                   stepTick;
    assign targetCode = vselS ? vset2Reg : vset1Reg;
    assign ramping = firstGoodReg && (curCodeReg != targetCode);
    // a new request restarts the step interval, so the first step of a new ramp is a full one
    assign rampStart = wrActive || (vselPrevReg != vselS);
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            vselPrevReg  <= 1'b0;
            rangePrevReg <= 1'b0;
        end
        else
        begin
            vselPrevReg  <= vselS;
            rangePrevReg <= ctrlReg.rangeBit;
        end
    end
    // the ramp needs no explicit start: a new target from the pin or a write differs from the
    // current code and stepping begins; before first good the code simply follows
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            curCodeReg <= '0;
        else if (!firstGoodReg || rangePrevReg != ctrlReg.rangeBit)
            curCodeReg <= targetCode;
        else if (stepTick && curCodeReg < targetCode)
            curCodeReg <= curCodeReg + `BBC_CODE_W'(1);
        else if (stepTick && curCodeReg > targetCode)
            curCodeReg <= curCodeReg - `BBC_CODE_W'(1);
    end
    bbc_step_timer u_step
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .run      (ramping && !rampStart),
        .slewCode (ctrlReg.slewCode),
        .stepTick (stepTick)
    );
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            setpointMv <= `BBC_OFS_LO_MV;
        else
            setpointMv <= 13'(curCodeReg) * `BBC_LSB_MV +
                          (ctrlReg.rangeBit ? `BBC_OFS_HI_MV : `BBC_OFS_LO_MV);
    end

    // forced pulse width needs first good; ramp bit adds it during ramps
    assign forcedPwmActive = firstGoodReg &&
                             (ctrlReg.forcedPulseWidthBit ||
                              (ctrlReg.rampPulseWidthBit && ramping));
    assign reverseLimitMa = forcedPwmActive ? `BBC_REV_LIMIT_MA : 12'h000;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            convMode <= BBC_BUCK;
        else if (vinHiS && !voutHiS)
            convMode <= BBC_BUCK;
        else if (voutHiS && !vinHiS)
            convMode <= BBC_BOOST;
        else
            convMode <= BBC_BB;
    end

    logic onPhaseReg, phaseBReg, idleReg;
    always_ff @(posedge clk)
    begin
        if (sys_rst || stateReg == BBC_OFF)
        begin
            onPhaseReg <= 1'b0;
            phaseBReg  <= 1'b0;
        end
        else if (cycleStart && !idleReg)
        begin
            onPhaseReg <= 1'b1;
            phaseBReg  <= 1'b0;
        end
        else if (onPhaseReg && peakReached)
        begin
            onPhaseReg <= 1'b0;
            phaseBReg  <= 1'b1;
        end
    end
    // power save: skip cycles at light load until the amplifier calls for a burst
    always_comb
    begin
        idleReg = !forcedPwmActive && lightLoad && !burstAboveThreshold;
    end
    logic syncOff;
    // diode emulation in power save: rectifier opens on negative current
    assign syncOff = !forcedPwmActive && currentNegative;
    always_ff @(posedge clk)
    begin
        if (sys_rst || stateReg == BBC_OFF)
            gateDrive <= '0;
        else
        begin
            case (convMode)
                BBC_BUCK:  gateDrive <= '{onPhaseReg, !onPhaseReg && phaseBReg && !syncOff,
                                          1'b0, 1'b1};
                BBC_BOOST: gateDrive <= '{1'b1, 1'b0, onPhaseReg,
                                          !onPhaseReg && phaseBReg && !syncOff};
                default:   gateDrive <= '{onPhaseReg, !onPhaseReg && !syncOff,
                                          onPhaseReg, !onPhaseReg && !syncOff};
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            regRdData <= '0;
        else if (!regRdStrobe)
            regRdData <= '0;
        else if (regAddr == ADDR_VSET1)
            regRdData <= {1'b0, vset1Reg};
        else if (regAddr == ADDR_VSET2)
            regRdData <= {1'b0, vset2Reg};
        else if (regAddr == ADDR_CTRL)
            regRdData <= {2'b00, ctrlReg};
        else if (regAddr == ADDR_STATUS)
            regRdData <= {1'b0, curCodeReg};
        else
            regRdData <= '0;
    end
endmodule // bbc_control

// ==== bbc_stage_model.sv ====
// power stage and current comparator stand-in for the control block
`timescale 1ns/1ns
module bbc_stage_model
    import bbc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      sys_rst,
    input  wire bbc_gate_s gateDrive,
    input  wire bbc_mode_e convMode,
    input  wire logic      goodLevel,
    input  wire logic      lightReq,
    output logic           cycleStart,
    output logic           peakReached,
    output logic           currentNegative,
    output logic           lightLoad,
    output logic           burstAboveThreshold,
    output logic           outAbove95,
    output logic           outBelow90
);
    logic [2:0] phase_reg;
    logic [1:0] onCnt_reg;
    logic       ctlOn;
    // a buck on phase and a boost off phase look alike at the gates, so the mode picks the control switch
    always_comb
    begin
        case (convMode)
            BBC_BUCK:  ctlOn = gateDrive.q1On;
            BBC_BOOST: ctlOn = gateDrive.q3On;
            default:   ctlOn = gateDrive.q1On && gateDrive.q3On;
        endcase
    end
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            phase_reg <= 3'h0;
        else
            phase_reg <= phase_reg + 3'h1;
    end
    always_ff @(posedge clk)
    begin
        if (!ctlOn)
            onCnt_reg <= 2'h0;
        else if (onCnt_reg != 2'h3)
            onCnt_reg <= onCnt_reg + 2'h1;
    end
    // peak trips after two cycles of charge, a slow-enough inductor
    assign peakReached = ctlOn && onCnt_reg == 2'h2;
    assign cycleStart = phase_reg == 3'h0;
    assign currentNegative = lightReq && !ctlOn && phase_reg[2];
    assign lightLoad = lightReq;
    assign burstAboveThreshold = lightReq && phase_reg == 3'h0;
    assign outAbove95 = goodLevel;
    assign outBelow90 = !goodLevel;
endmodule // bbc_stage_model

// ==== bbc_control_asserts.sv ====
// port-level assertions for the buck-boost control block
`timescale 1ns/1ns
module bbc_control_asserts
    import bbc_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        vinAboveVout,
    input wire logic        voutAboveVin,
    input wire logic        peakReached,
    input wire bbc_gate_s   gateDrive,
    input wire bbc_mode_e   convMode,
    input wire logic        forcedPwmActive,
    input wire logic [12:0] setpointMv,
    input wire logic [11:0] reverseLimitMa,
    input wire logic        powerGoodN
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic seenGood_reg;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            seenGood_reg <= 1'b0;
        else if (!powerGoodN)
            seenGood_reg <= 1'b1;
    end
    property p_buck_sel;
        (vinAboveVout && !voutAboveVin) [*5] |-> ##[0:10] convMode == BBC_BUCK;
    endproperty
    a_buck_sel: assert property (p_buck_sel) else $error("buck not chosen");
    property p_buck_gate;
        convMode == BBC_BUCK && $past(convMode) == BBC_BUCK |-> !gateDrive.q3On;
    endproperty
    a_buck_gate: assert property (p_buck_gate) else $error("third on in buck");
    property p_boost_gate;
        convMode == BBC_BOOST && $past(convMode) == BBC_BOOST |-> !gateDrive.q2On;
    endproperty
    a_boost_gate: assert property (p_boost_gate) else $error("second on in boost");
    property p_peak_end;
        peakReached && convMode == BBC_BUCK ##1 convMode == BBC_BUCK |-> ##[0:1] !gateDrive.q1On;
    endproperty
    a_peak_end: assert property (p_peak_end) else $error("on phase kept");
    property p_rev_limit;
        reverseLimitMa == (forcedPwmActive ? 12'h514 : 12'h000);
    endproperty
    a_rev_limit: assert property (p_rev_limit) else $error("reverse limit");
    property p_startup_psm;
        !seenGood_reg && powerGoodN |-> !forcedPwmActive;
    endproperty
    a_startup_psm: assert property (p_startup_psm) else $error("pwm before good");
    property p_sp_grid;
        setpointMv >= 13'h0708 && setpointMv <= 13'h1450 && setpointMv % 13'h0019 == 13'h0000;
    endproperty
    a_sp_grid: assert property (p_sp_grid) else $error("setpoint off grid");
    // ramp steps only; range changes are not made once power is good
    property p_step;
        !powerGoodN && !$past(powerGoodN) && $changed(setpointMv)
        |-> setpointMv - $past(setpointMv) == 13'h0019 || $past(setpointMv) - setpointMv == 13'h0019;
    endproperty
    a_step: assert property (p_step) else $error("step not 25 mV");
endmodule // bbc_control_asserts
bind bbc_control bbc_control_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
    .vinAboveVout(vinAboveVout), .voutAboveVin(voutAboveVin), .peakReached(peakReached),
    .gateDrive(gateDrive), .convMode(convMode), .forcedPwmActive(forcedPwmActive),
    .setpointMv(setpointMv), .reverseLimitMa(reverseLimitMa), .powerGoodN(powerGoodN));

// ==== test_bbc_control.sv ====
// self-checking bench for the buck-boost mode and ramp control block
`timescale 1ns/1ns
module test_bbc_control;
    import bbc_pkg::*;
    logic        clk, sys_rst, regWrStrobe, regRdStrobe, enablePin, voltageSelectPin;
    logic        vinAboveVout, voutAboveVin, goodLevel, lightReq, cycleStart, powerGoodN;
    logic        peakReached, currentNegative, lightLoad, burstAboveThreshold;
    logic        outAbove95, outBelow90, forcedPwmActive;
    logic [3:0]  regAddr;
    logic [7:0]  regWrData, regRdData;
    bbc_gate_s   gateDrive;
    bbc_mode_e   convMode;
    logic [12:0] setpointMv, prevSp;
    logic [11:0] softStartLevel, reverseLimitMa;
    logic [6:0]  vset [2];
    int          error_cnt = 0, checks_done = 0, cyc = 0, t0, t1, n;
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    bbc_control DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .enablePin(enablePin), .voltageSelectPin(voltageSelectPin),
        .vinAboveVout(vinAboveVout), .voutAboveVin(voutAboveVin), .peakReached(peakReached),
        .currentNegative(currentNegative), .lightLoad(lightLoad),
        .burstAboveThreshold(burstAboveThreshold), .outAbove95(outAbove95),
        .outBelow90(outBelow90), .cycleStart(cycleStart), .gateDrive(gateDrive),
        .convMode(convMode), .forcedPwmActive(forcedPwmActive), .setpointMv(setpointMv),
        .softStartLevel(softStartLevel), .reverseLimitMa(reverseLimitMa),
        .powerGoodN(powerGoodN));
    bbc_stage_model u_stage (.clk(clk), .sys_rst(sys_rst), .gateDrive(gateDrive),
        .convMode(convMode),
        .goodLevel(goodLevel), .lightReq(lightReq), .cycleStart(cycleStart),
        .peakReached(peakReached), .currentNegative(currentNegative), .lightLoad(lightLoad),
        .burstAboveThreshold(burstAboveThreshold), .outAbove95(outAbove95),
        .outBelow90(outBelow90));
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
        @(posedge clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clk);
        regRdStrobe <= 1'b0;
        @(negedge clk);
        check(what, {8'h00, exp}, {8'h00, regRdData});
    endtask
    // full-width expectation, so a setpoint port too narrow for 2.275 V shows up
    function automatic logic [15:0] spExp(logic [6:0] c, logic rng);
        return 16'(c) * 16'h0019 + (rng ? 16'h07e9 : 16'h0708);
    endfunction
    function automatic int stepExp(logic [1:0] s);
        int rate [4] = '{1000, 2500, 5000, 10000};
        return 250000 / rate[s];
    endfunction
    task automatic waitStep(output int at);
        @(negedge clk);
        prevSp = setpointMv;
        for (n = 0; n < 400 && setpointMv === prevSp; n++) @(negedge clk);
        at = cyc;
        check("step size", 16'h0019, (setpointMv > prevSp) ? setpointMv - prevSp : prevSp - setpointMv);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #(40000 * 100);
        error_cnt++;
        summarize();
    end
    initial
    begin
        void'($urandom(32'hf19bd031));
        {sys_rst, regAddr, regWrData, regWrStrobe, regRdStrobe} = {1'b1, 14'h0};
        {enablePin, voltageSelectPin, vinAboveVout, voutAboveVin, goodLevel, lightReq} = 6'h0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(4'h2, 8'h00, "ctrl reset");
        rd(4'h5, 8'h00, "unmapped");
        vset[0] = 7'h02 + 7'($urandom % 6);
        vset[1] = 7'h0c + 7'($urandom % 8);
        wr(4'h0, {1'b0, vset[0]});
        wr(4'h1, {1'b0, vset[1]});
        rd(4'h1, {1'b0, vset[1]}, "second setting");
        wr(4'h2, 8'h30);
        t0 = cyc;
        repeat (4) @(negedge clk);
        check("sp start", spExp(vset[0], 1'b0), 16'(setpointMv));
        vset[0] = vset[0] + 7'h01;
        wr(4'h0, {1'b0, vset[0]});
        repeat (3) @(negedge clk);
        check("sp immediate", spExp(vset[0], 1'b0), 16'(setpointMv));
        wr(4'h2, 8'h34);
        repeat (3) @(negedge clk);
        check("sp range", spExp(vset[0], 1'b1), 16'(setpointMv));
        wr(4'h2, 8'h30);
        @(negedge clk);
        check("pwm in startup", 16'h0, 16'(forcedPwmActive));
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            {voutAboveVin, vinAboveVout} <= 2'(m);
            repeat (16) @(negedge clk);
            check("mode", m == 1 ? BBC_BUCK : m == 2 ? BBC_BOOST : BBC_BB, 16'(convMode));
        end
        for (n = 0; n < 3000 && softStartLevel !== prevSp; n++)
        begin
            prevSp = softStartLevel[10:0];
            repeat (2) @(negedge clk);
        end
        check("soft start", 16'h1, 16'(cyc - t0 <= 2500 && cyc - t0 >= 1700));
        @(posedge clk);
        goodLevel <= 1'b1;
        lightReq <= 1'b1;
        repeat (8) @(negedge clk);
        check("good", 16'h0, 16'(powerGoodN));
        check("pwm", 16'h1, 16'(forcedPwmActive));
        check("rev limit", 16'h0514, 16'(reverseLimitMa));
        for (int s = 0; s < 4; s++)
        begin
            wr(4'h2, {4'h2, 2'h2, 2'(s)});
            voltageSelectPin <= ~voltageSelectPin;
            waitStep(t0);
            waitStep(t1);
            check("interval", 16'(stepExp(2'(s))), 16'(t1 - t0));
            check("ramp pwm", 16'h1, 16'(forcedPwmActive));
            for (n = 0; n < 5000 && 16'(setpointMv) !== spExp(vset[s % 2 == 0], 1'b0); n++)
                @(negedge clk);
            check("ramp end", spExp(vset[s % 2 == 0], 1'b0), 16'(setpointMv));
            rd(4'h3, {1'b0, vset[s % 2 == 0]}, "ramped code");
        end
        wr(4'h0, {1'b0, vset[0] + 7'h01});
        waitStep(t0);
        wr(4'h2, 8'h00);
        repeat (3) @(negedge clk);
        check("disabled", 16'h0, 16'(softStartLevel));
        @(posedge clk);
        enablePin <= 1'b1;
        repeat (6) @(negedge clk);
        check("pin enable", 16'h1, 16'(softStartLevel != 0 && softStartLevel < 12));
        summarize();
    end
endmodule // test_bbc_control
